// [pkg/pmitl_pkg.sv]
// constants for the power-management interrupt trigger latch
package pmitl_pkg;
    // i/o port pair of the index/data access
    localparam logic [15:0] PMITL_PORT_INDEX = 16'h0024;
    localparam logic [15:0] PMITL_PORT_DATA = 16'h0026;
    // register indices
    localparam logic [7:0] PMITL_IDX_CTRL = 8'h20;
    localparam logic [7:0] PMITL_IDX_MASK_LOW = 8'h23;
    localparam logic [7:0] PMITL_IDX_MASK_HIGH = 8'h24;
    localparam logic [7:0] PMITL_IDX_FLAGS_LOW = 8'h25;
    localparam logic [7:0] PMITL_IDX_FLAGS_HIGH = 8'h26;
    // field positions
    localparam int PMITL_BIT_ACT_ENABLE = 2;
    localparam int PMITL_BIT_SLAVE_LOCK = 0;
    localparam int PMITL_BIT_RESERVED = 2;
    // reset values
    localparam logic [7:0] PMITL_RST_INDEX = 8'h00;
    localparam logic PMITL_RST_ACT_ENABLE = 1'b0;
    localparam logic [7:0] PMITL_RST_MASK = 8'hff;
    localparam logic [15:0] PMITL_RST_FLAGS = 16'h0000;
    localparam logic [7:0] PMITL_RST_RDATA = 8'h00;
    // source bits that exist (bit 2 of the low byte is reserved)
    localparam logic [15:0] PMITL_SRC_IMPL = 16'hfffb;
endpackage : pmitl_pkg

// [verilog/pmitl_trigger_latch.sv]
// power-management interrupt trigger masks, sticky source flags and index/data access
//
// How it works
// R1: high mask bits block lines 8 to 15
// R2: low flag bit 0 marks slave-lock cause
// R3: low flags mark lines 1,3-7; bit 2 zero
// R4: high flags mark lines 8 to 15
// R5: writing zero clears a flag, one keeps
// R6: software uses ports 24h index, 26h data
// R7: low mask blocks slave lock, lines 1,3-7
// R8: enable bit lets primary activity interrupt
// R9: flags sticky until cleared; masks reset high
module pmitl_trigger_latch
    import pmitl_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic [15:0] IO_ADDR,
    input wire logic IO_WR,
    input wire logic IO_RD,
    input wire logic [7:0] IO_WDATA,
    output logic [7:0] IO_RDATA,
    input wire logic [15:0] IRQ_LINES,
    input wire logic DISTRIBUTED_DMA_SLAVE_LOCK,
    input wire logic PRIMARY_ACTIVITY,
    output logic POWER_MGMT_INTERRUPT
);

    logic [7:0] index_ff;
    logic [7:0] nxt_index;
    logic act_enable_ff;
    logic nxt_act_enable;
    logic [7:0] mask_low_ff;
    logic [7:0] nxt_mask_low;
    logic [7:0] mask_high_ff;
    logic [7:0] nxt_mask_high;
    logic [15:0] flags_ff;
    logic [15:0] nxt_flags;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic irq_out_ff;
    logic nxt_irq_out;
    logic wr_index;
    logic wr_data;
    logic rd_index;
    logic rd_data;
    logic [15:0] src_vec;
    logic [15:0] mask_vec;
    logic [15:0] clr_vec;

    // access decode: index port then data port [R6]
    assign wr_index = IO_WR && (IO_ADDR == PMITL_PORT_INDEX);
    assign wr_data = IO_WR && (IO_ADDR == PMITL_PORT_DATA);
    assign rd_index = IO_RD && (IO_ADDR == PMITL_PORT_INDEX);
    assign rd_data = IO_RD && (IO_ADDR == PMITL_PORT_DATA);

    // source vector laid out as the two flag registers [R2] [R3] [R4]
    always_comb begin
        src_vec = IRQ_LINES & PMITL_SRC_IMPL;
        src_vec[PMITL_BIT_SLAVE_LOCK] = DISTRIBUTED_DMA_SLAVE_LOCK;
    end

    assign mask_vec = {mask_high_ff, mask_low_ff};

    // register writes
    always_comb begin
        nxt_index = index_ff;
        nxt_act_enable = act_enable_ff;
        nxt_mask_low = mask_low_ff;
        nxt_mask_high = mask_high_ff;
        clr_vec = 16'h0000;
        if (wr_index) begin
            nxt_index = IO_WDATA;
        end
        if (wr_data) begin
            unique case (index_ff)
                PMITL_IDX_CTRL: begin
                    nxt_act_enable = IO_WDATA[PMITL_BIT_ACT_ENABLE];
                end
                PMITL_IDX_MASK_LOW: begin
                    nxt_mask_low = IO_WDATA; // [R7]
                    // reserved mask bit stays at its reset value
                    nxt_mask_low[PMITL_BIT_RESERVED] = 1'b1;
                end
                PMITL_IDX_MASK_HIGH: begin
                    nxt_mask_high = IO_WDATA; // [R1]
                end
                PMITL_IDX_FLAGS_LOW: begin
                    clr_vec[7:0] = ~IO_WDATA; // [R5]
                end
                PMITL_IDX_FLAGS_HIGH: begin
                    clr_vec[15:8] = ~IO_WDATA; // [R5]
                end
                default: begin
                    // other indices belong to other blocks
                end
            endcase
        end
    end

    // sticky flags: a new trigger wins over a clear in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_flag
            always_comb begin
                if (PMITL_SRC_IMPL[gi] && src_vec[gi] && !mask_vec[gi]) begin
                    nxt_flags[gi] = 1'b1; // [R9] [R1] [R7]
                end else if (clr_vec[gi]) begin
                    nxt_flags[gi] = 1'b0; // [R5]
                end else begin
                    nxt_flags[gi] = flags_ff[gi]; // [R9]
                end
            end
        end
    endgenerate

    // read data and interrupt output
    always_comb begin
        nxt_rdata = rdata_ff;
        if (rd_index) begin
            nxt_rdata = index_ff;
        end else if (rd_data) begin
            unique case (index_ff)
                PMITL_IDX_CTRL: nxt_rdata = 8'(act_enable_ff) << PMITL_BIT_ACT_ENABLE;
                PMITL_IDX_MASK_LOW: nxt_rdata = mask_low_ff;
                PMITL_IDX_MASK_HIGH: nxt_rdata = mask_high_ff;
                PMITL_IDX_FLAGS_LOW: nxt_rdata = flags_ff[7:0]; // [R2] [R3]
                PMITL_IDX_FLAGS_HIGH: nxt_rdata = flags_ff[15:8]; // [R4]
                default: nxt_rdata = 8'h00;
            endcase
        end
        // level while any flag stands, plus one cycle for each cycle that enabled primary activity is high
        nxt_irq_out = (|nxt_flags) || (PRIMARY_ACTIVITY && act_enable_ff); // [R8]
    end

    // all state frozen while the clock enable is low
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            index_ff <= PMITL_RST_INDEX;
            act_enable_ff <= PMITL_RST_ACT_ENABLE;
            mask_low_ff <= PMITL_RST_MASK; // [R9]
            mask_high_ff <= PMITL_RST_MASK; // [R9]
            flags_ff <= PMITL_RST_FLAGS; // [R9]
            rdata_ff <= PMITL_RST_RDATA;
            irq_out_ff <= 1'b0;
        end else if (CE) begin
            index_ff <= nxt_index;
            act_enable_ff <= nxt_act_enable;
            mask_low_ff <= nxt_mask_low;
            mask_high_ff <= nxt_mask_high;
            flags_ff <= nxt_flags;
            rdata_ff <= nxt_rdata;
            irq_out_ff <= nxt_irq_out;
        end
    end

    assign IO_RDATA = rdata_ff;
    assign POWER_MGMT_INTERRUPT = irq_out_ff;

    // checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    // index already standing, so any spacing between index and data access is covered
    sequence s_sel_flags_low;
        CE && index_ff == PMITL_IDX_FLAGS_LOW;
    endsequence

    sequence s_write_zero_bit0;
        CE && wr_data && !IO_WDATA[0] && !DISTRIBUTED_DMA_SLAVE_LOCK;
    endsequence

    sequence s_sel_flags_high;
        CE && index_ff == PMITL_IDX_FLAGS_HIGH;
    endsequence

    sequence s_read_data;
        CE && rd_data && !IO_WR;
    endsequence

    line_high_set_a: assert property ( // [R4]
        CE && IRQ_LINES[8] && !mask_high_ff[0] |=> flags_ff[8])
        else $error("unmasked line 8 did not set its flag");

    masked_no_set_a: assert property ( // [R1]
        CE && !flags_ff[15] && mask_high_ff[7] |=> !flags_ff[15])
        else $error("masked line 15 set its flag");

    slave_lock_flag_a: assert property ( // [R2]
        CE && DISTRIBUTED_DMA_SLAVE_LOCK && !mask_low_ff[0] |=> flags_ff[0])
        else $error("slave lock did not set low flag bit 0");

    reserved_bit_a: assert property ( // [R3]
        !flags_ff[PMITL_BIT_RESERVED] && mask_low_ff[PMITL_BIT_RESERVED])
        else $error("reserved low flag or mask bit wrong");

    masked_low_a: assert property ( // [R7]
        CE && mask_low_ff[3] && !flags_ff[3] && !wr_data |=> !flags_ff[3])
        else $error("masked line 3 set its flag");

    clear_zero_a: assert property ( // [R5]
        s_sel_flags_low ##0 s_write_zero_bit0 |=> !flags_ff[0])
        else $error("writing zero did not clear flag bit 0");

    write_one_keep_a: assert property ( // [R5]
        s_sel_flags_high ##0 (CE && wr_data && IO_WDATA[0] && flags_ff[8]) |=> flags_ff[8])
        else $error("writing one cleared flag bit 8");

    flag_sticky_a: assert property ( // [R9]
        flags_ff[12] && !(CE && wr_data) |=> flags_ff[12])
        else $error("flag 12 dropped without a clear");

    act_enable_a: assert property ( // [R8]
        CE && PRIMARY_ACTIVITY && act_enable_ff |=> POWER_MGMT_INTERRUPT)
        else $error("enabled primary activity gave no interrupt");

    act_disable_a: assert property ( // [R8]
        CE && !act_enable_ff && ~|nxt_flags |=> !POWER_MGMT_INTERRUPT)
        else $error("interrupt raised with enable low and no flags");

    read_flags_a: assert property ( // [R6]
        s_read_data ##0 (index_ff == PMITL_IDX_FLAGS_HIGH) |=> IO_RDATA == $past(flags_ff[15:8]))
        else $error("data port read of high flags wrong");

endmodule : pmitl_trigger_latch

// [verif/pmitl_src_model.sv]
// model of the interrupt sources and activity event feeding the latch
module pmitl_src_model (
    input wire logic clk,
    input wire logic [15:0] want_lines,
    input wire logic want_lock,
    input wire logic want_act,
    output logic [15:0] irq_lines,
    output logic lock,
    output logic act
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        irq_lines = 16'h0000;
        lock = 1'b0;
        act = 1'b0;
    end
    // wants taken on the edge, levels move just after it: no race with the bench
    always @(posedge clk) begin
        irq_lines <= #1 want_lines;
        lock <= #1 want_lock;
        act <= #1 want_act;
    end
endmodule : pmitl_src_model

// [verif/tb_top.sv]
// self-checking bench for the trigger latch over the index/data ports
module tb_top
    import pmitl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0, lk = 1'b0, act_req = 1'b0;
    logic hit = 1'b0, lock, act, pm_irq;
    logic [15:0] addr = 16'h0000, ln = 16'h0000, m, irq;
    logic [7:0] wd = 8'h00, rdat, v;
    int err_count = 0, tests_run = 0, i;
    pmitl_src_model pmitl_src_model_inst (.clk(clk), .want_lines(ln), .want_lock(lk),
        .want_act(act_req), .irq_lines(irq), .lock(lock), .act(act));
    pmitl_trigger_latch pmitl_trigger_latch_inst (.CLK(clk), .RST(rst), .CE(ce),
        .IO_ADDR(addr), .IO_WR(wr), .IO_RD(rd), .IO_WDATA(wd), .IO_RDATA(rdat),
        .IRQ_LINES(irq), .DISTRIBUTED_DMA_SLAVE_LOCK(lock), .PRIMARY_ACTIVITY(act),
        .POWER_MGMT_INTERRUPT(pm_irq));
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    // pulses are short, so catch any high cycle
    always @(posedge clk) if (pm_irq === 1'b1) hit <= 1'b1;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        #1 addr = a;
        wr = w;
        rd = ~w;
        wd = d;
        @(posedge clk);
        #1 wr = 1'b0;
        rd = 1'b0;
        wd = ~d;
        @(posedge clk);
        #1 v = rdat;
    endtask : bus
    task automatic iwr(input logic [7:0] idx, input logic [7:0] d);
        bus(PMITL_PORT_INDEX, 1'b1, idx);
        bus(PMITL_PORT_DATA, 1'b1, d);
    endtask : iwr
    task automatic ird(input logic [7:0] idx, input logic [7:0] exp);
        bus(PMITL_PORT_INDEX, 1'b1, idx);
        bus(PMITL_PORT_DATA, 1'b0, 8'h00);
        chk(v, exp);
    endtask : ird
    task automatic fire(input logic [15:0] l, input logic k, input logic a);
        hit = 1'b0;
        ln = l;
        lk = k;
        act_req = a;
        repeat (2) @(posedge clk);
        #1 ln = 16'h0000;
        lk = 1'b0;
        act_req = 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask : fire
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop
    initial begin
        #200000;
        err_count++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge clk);
        #1 rst = 0;
        ird(PMITL_IDX_MASK_LOW, 8'hff);
        ird(PMITL_IDX_MASK_HIGH, 8'hff);
        ird(PMITL_IDX_FLAGS_HIGH, 8'h00);
        ird(PMITL_IDX_CTRL, 8'h00);
        fire(16'hffff, 1'b1, 1'b1);
        chk({7'h00, hit}, 8'h00);
        ird(PMITL_IDX_FLAGS_LOW, 8'h00);
        bus(PMITL_PORT_INDEX, 1'b0, 8'h00);
        chk(v, PMITL_IDX_FLAGS_LOW);
        $display("test reset_and_masked done");
        for (i = 0; i < 16; i++) if (i != 2) begin
            m = ~(16'h0001 << i);
            iwr(PMITL_IDX_MASK_LOW, m[7:0]);
            iwr(PMITL_IDX_MASK_HIGH, m[15:8]);
            fire(16'hffff, 1'b1, 1'b0);
            chk({7'h00, hit}, 8'h01);
            ird(PMITL_IDX_FLAGS_LOW, ~m[7:0]);
            ird(PMITL_IDX_FLAGS_HIGH, ~m[15:8]);
            iwr(PMITL_IDX_FLAGS_HIGH, 8'hff);
            iwr(PMITL_IDX_FLAGS_LOW, 8'hff);
            ird(i < 8 ? PMITL_IDX_FLAGS_LOW : PMITL_IDX_FLAGS_HIGH, 8'h01 << i % 8);
            iwr(PMITL_IDX_FLAGS_LOW, m[7:0]);
            iwr(PMITL_IDX_FLAGS_HIGH, m[15:8]);
            hit = 1'b0;
            repeat (2) @(posedge clk);
            chk({7'h00, hit}, 8'h00);
        end
        $display("test per_source done");
        iwr(PMITL_IDX_MASK_LOW, 8'h00);
        ird(PMITL_IDX_MASK_LOW, 8'h04);
        fire(16'hffff, 1'b1, 1'b0);
        ird(PMITL_IDX_FLAGS_LOW, 8'hfb);
        iwr(PMITL_IDX_MASK_LOW, 8'hff);
        iwr(PMITL_IDX_FLAGS_LOW, 8'h00);
        ird(PMITL_IDX_FLAGS_LOW, 8'h00);
        // line 15 is still unmasked from the loop and left its flag standing
        iwr(PMITL_IDX_MASK_HIGH, 8'hff);
        iwr(PMITL_IDX_FLAGS_HIGH, 8'h00);
        ird(PMITL_IDX_FLAGS_HIGH, 8'h00);
        $display("test reserved_bit done");
        iwr(PMITL_IDX_CTRL, 8'hff);
        ird(PMITL_IDX_CTRL, 8'h04);
        fire(16'h0000, 1'b0, 1'b1);
        chk({7'h00, hit}, 8'h01);
        hit = 1'b0;
        repeat (3) @(posedge clk);
        chk({7'h00, hit}, 8'h00);
        ird(8'h30, 8'h00);
        bus(16'h0025, 1'b1, 8'h26);
        bus(PMITL_PORT_INDEX, 1'b0, 8'h00);
        chk(v, 8'h30);
        $display("test activity_and_ports done");
        // an unmasked line while the clock enable is low must leave nothing behind
        iwr(PMITL_IDX_MASK_HIGH, 8'hfe);
        ce = 1'b0;
        fire(16'h0100, 1'b0, 1'b0);
        chk({7'h00, hit}, 8'h00);
        ce = 1'b1;
        ird(PMITL_IDX_FLAGS_HIGH, 8'h00);
        fire(16'h0100, 1'b0, 1'b0);
        chk({7'h00, hit}, 8'h01);
        ird(PMITL_IDX_FLAGS_HIGH, 8'h01);
        $display("test clock_enable done");
        report_and_stop();
    end
endmodule : tb_top
